/* inc/dtm_pkg.sv */
// constants and types of the dual down-timer pair
package dtm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_MODE = 8'hC9;
  localparam logic [7:0] ADDR_B_LO = 8'hCA;
  localparam logic [7:0] ADDR_B_HI = 8'hCB;
  localparam logic [7:0] ADDR_A_LO = 8'hCC;
  localparam logic [7:0] ADDR_A_HI = 8'hCD;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_A_RUN = 0;
  localparam int CTRL_A_ELAPSED = 1;
  localparam int CTRL_A_MASK = 3;
  localparam int CTRL_B_RUN = 4;
  localparam int CTRL_B_ELAPSED = 5;
  localparam int CTRL_B_MASK = 7;

  // ****************************************
  // mode register fields
  // ****************************************
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_SEL_W = 3;
  localparam int CSEL_A_LSB = 4;
  localparam int CSEL_B_LSB = 6;
  localparam int CSEL_W = 2;

  // timer_mode_select codes
  localparam logic [2:0] MODE_A16_RELOAD = 3'h0;
  localparam logic [2:0] MODE_A16_B8 = 3'h1;
  localparam logic [2:0] MODE_A8_B8 = 3'h2;
  localparam logic [2:0] MODE_SPLIT_A = 3'h3;
  localparam logic [2:0] MODE_B16_RELOAD = 3'h4;
  localparam logic [2:0] MODE_A8_B16 = 3'h5;
  localparam logic [2:0] MODE_A16_B16 = 3'h6;
  localparam logic [2:0] MODE_CAL = 3'h7;

  // clock source select codes
  localparam logic [1:0] CSEL_SYS = 2'h0;
  localparam logic [1:0] CSEL_DIV4 = 2'h1;
  localparam logic [1:0] CSEL_DIV16 = 2'h2;
  localparam logic [1:0] CSEL_EXT = 2'h3;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  typedef enum logic {
    CAL_IDLE,
    CAL_COUNT
  } dtm_cal_type;

endpackage : dtm_pkg

/* hw/dtm_timer.sv */
// dual down-timer pair with eight modes and bit-rate strobe
// Notes on behaviour
// RQ1: both timers count on the clock source chosen in the mode register, down except timer A in mode 7.
// RQ2: setting a run bit starts that timer; elapse sets its elapsed flag.
// RQ3: reloading modes reload and restart; others stop and clear the run bit.
// RQ4: a 3-bit mode select field chooses one of eight modes.
// RQ5: mode 0: timer A is 16-bit, flag set on underflow 00 to FF.
// RQ6: mode 0: reload from timer B bytes; flag sticky until software clears.
// RQ7: mode 1: A 16-bit one-shot; B 8-bit, low byte counts, high reloads.
// RQ8: mode 2: both timers 8-bit reloading with their own run and flag.
// RQ9: mode 3: A splits into two 8-bit one-shots, high half uses B bits.
// RQ10: mode 3: B free-runs as 8-bit bit-rate timer, no run or flag.
// RQ11: mode 4: B 16-bit, reloads from A bytes, sticky flag.
// RQ12: mode 5: A 8-bit reloading; B 16-bit one-shot.
// RQ13: mode 6: both timers 16-bit one-shots.
// RQ14: mode 7: A counts cycles between two rising edges of the slow oscillator.
// RQ15: mode 7 is meant for calibration code, not for applications.
// RQ16: timer B drives the bit-rate strobe in modes 1 to 7.
// RQ17: mode 7: B 8-bit reloading with its own run and flag.
// RQ18: a set mask bit blocks that timer's interrupt request.
// RQ19: all registers reset to zero; timers stopped, flags clear.
// RQ20: strobe is a one-cycle pulse on each timer B underrun.
// RQ21: a hardware flag set wins over a software clear in the same cycle.
module dtm_timer #(
  parameter int PRE_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [dtm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dtm_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [dtm_pkg::DATA_W-1:0] rd_data_o,
  input wire logic ext_tick_i,
  input wire logic lp_osc_i,
  output logic bit_strobe_o,
  output logic irq_a_o,
  output logic irq_b_o
);
  import dtm_pkg::*;

  if (PRE_W < 4) begin : g_check
    $error("PRE_W must be at least 4");
  end

  typedef struct packed {
    logic [7:0] a_lo;
    logic [7:0] a_hi;
    logic [7:0] b_lo;
    logic [7:0] b_hi;
    logic run_a;
    logic run_b;
    logic el_a;
    logic el_b;
    logic mask_a;
    logic mask_b;
    logic [2:0] mode;
    logic [1:0] csel_a;
    logic [1:0] csel_b;
    logic [PRE_W-1:0] pre;
    logic lp;
    dtm_cal_type cal;
    logic strobe;
    logic [7:0] rdata;
  } dtm_state_type;

  dtm_state_type q, d;
  logic tick_a, tick_b, lp_rise;
  logic w_ctrl, w_mode, w_a_lo, w_a_hi, w_b_lo, w_b_hi;
  logic a_wide, a_reload, b_wide, b_reload, b_active;
  logic uf_a, uf_ah, uf_b, set_a, set_b, clr_a, clr_b;
  logic [15:0] cnt_a, cnt_b;

  // ****************************************
  // clock source selection
  // ****************************************
  function automatic logic pick_tick(input logic [1:0] sel, input logic [PRE_W-1:0] pre, input logic ext);
    logic t;
    t = 1'b1;
    unique case (sel)
      CSEL_SYS: t = 1'b1;
      CSEL_DIV4: t = &pre[1:0];
      CSEL_DIV16: t = &pre[3:0];
      CSEL_EXT: t = ext;
    endcase
    return t;
  endfunction

  assign tick_a = pick_tick(q.csel_a, q.pre, ext_tick_i); // RQ1
  assign tick_b = pick_tick(q.csel_b, q.pre, ext_tick_i); // RQ1
  assign lp_rise = lp_osc_i && !q.lp;

  assign w_ctrl = wr_i && (addr_i == ADDR_CTRL);
  assign w_mode = wr_i && (addr_i == ADDR_MODE);
  assign w_a_lo = wr_i && (addr_i == ADDR_A_LO);
  assign w_a_hi = wr_i && (addr_i == ADDR_A_HI);
  assign w_b_lo = wr_i && (addr_i == ADDR_B_LO);
  assign w_b_hi = wr_i && (addr_i == ADDR_B_HI);

  // ****************************************
  // mode decode
  // ****************************************
  always_comb begin
    a_wide = (q.mode == MODE_A16_RELOAD) || (q.mode == MODE_A16_B8) || (q.mode == MODE_A16_B16);
    a_reload = (q.mode == MODE_A16_RELOAD) || (q.mode == MODE_A8_B8) || (q.mode == MODE_A8_B16);
    b_wide = (q.mode == MODE_B16_RELOAD) || (q.mode == MODE_A8_B16) || (q.mode == MODE_A16_B16);
    b_reload = !b_wide || (q.mode == MODE_B16_RELOAD); // RQ3
    // split mode runs B without a run bit; mode 0 leaves B idle
    b_active = (q.mode == MODE_SPLIT_A) || (q.mode != MODE_A16_RELOAD && q.run_b); // RQ10
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.strobe = 1'b0;
    d.rdata = BYTE_ZERO;
    d.pre = q.pre + 1'b1;
    d.lp = lp_osc_i;
    cnt_a = {q.a_hi, q.a_lo};
    cnt_b = {q.b_hi, q.b_lo};
    uf_a = 1'b0;
    uf_ah = 1'b0;
    uf_b = 1'b0;
    set_a = 1'b0;
    set_b = 1'b0;
    clr_a = 1'b0;
    clr_b = 1'b0;

    // timer A
    if (q.mode == MODE_CAL) begin
      unique case (q.cal)
        CAL_IDLE: begin
          if (q.run_a && lp_rise) begin
            d.cal = CAL_COUNT; // RQ14
          end
        end
        CAL_COUNT: begin
          if (lp_rise || !q.run_a) begin
            d.cal = CAL_IDLE;
            clr_a = 1'b1; // RQ14
          end else if (tick_a) begin
            set_a = (cnt_a == WORD_ONES); // RQ14
            cnt_a = cnt_a + WORD_ONE;
          end
        end
      endcase
    end else begin
      d.cal = CAL_IDLE;
      if (q.run_a && tick_a && q.mode != MODE_B16_RELOAD) begin
        if (a_wide) begin
          uf_a = (cnt_a == WORD_ZERO); // RQ5
          if (uf_a && q.mode == MODE_A16_RELOAD) begin
            cnt_a = {q.b_hi, q.b_lo}; // RQ6
          end else begin
            cnt_a = cnt_a - WORD_ONE; // RQ1
          end
        end else begin
          uf_a = (q.a_lo == BYTE_ZERO);
          if (uf_a && a_reload) begin
            cnt_a[7:0] = q.a_hi; // RQ8
          end else begin
            cnt_a[7:0] = q.a_lo - BYTE_ONE;
          end
        end
        set_a = uf_a; // RQ2
        clr_a = uf_a && !a_reload; // RQ3
      end
      // split mode: upper byte of A is a one-shot driven by B's bits
      if (q.mode == MODE_SPLIT_A && q.run_b && tick_a) begin
        uf_ah = (q.a_hi == BYTE_ZERO);
        cnt_a[15:8] = q.a_hi - BYTE_ONE; // RQ9
        set_b = uf_ah; // RQ9
        clr_b = uf_ah; // RQ9
      end
    end

    // timer B
    if (b_active && tick_b) begin
      if (b_wide) begin
        uf_b = (cnt_b == WORD_ZERO);
        if (uf_b && b_reload) begin
          cnt_b = {q.a_hi, q.a_lo}; // RQ11
        end else begin
          cnt_b = cnt_b - WORD_ONE; // RQ12 RQ13
        end
      end else begin
        uf_b = (q.b_lo == BYTE_ZERO);
        if (uf_b) begin
          cnt_b[7:0] = q.b_hi; // RQ7 RQ17
        end else begin
          cnt_b[7:0] = q.b_lo - BYTE_ONE;
        end
      end
      d.strobe = uf_b; // RQ16 RQ20
      if (q.mode != MODE_SPLIT_A) begin
        set_b = uf_b; // RQ2
        clr_b = uf_b && !b_reload; // RQ3
      end
    end

    d.a_lo = cnt_a[7:0];
    d.a_hi = cnt_a[15:8];
    d.b_lo = cnt_b[7:0];
    d.b_hi = cnt_b[15:8];
    if (clr_a) begin
      d.run_a = 1'b0;
    end
    if (clr_b) begin
      d.run_b = 1'b0;
    end

    // software writes override the counters and run bits
    if (w_a_lo) begin
      d.a_lo = wr_data_i;
    end
    if (w_a_hi) begin
      d.a_hi = wr_data_i;
    end
    if (w_b_lo) begin
      d.b_lo = wr_data_i;
    end
    if (w_b_hi) begin
      d.b_hi = wr_data_i;
    end
    if (w_mode) begin
      d.mode = wr_data_i[MODE_SEL_LSB +: MODE_SEL_W]; // RQ4
      d.csel_a = wr_data_i[CSEL_A_LSB +: CSEL_W];
      d.csel_b = wr_data_i[CSEL_B_LSB +: CSEL_W];
    end
    if (w_ctrl) begin
      d.run_a = wr_data_i[CTRL_A_RUN];
      d.run_b = wr_data_i[CTRL_B_RUN];
      d.el_a = wr_data_i[CTRL_A_ELAPSED];
      d.el_b = wr_data_i[CTRL_B_ELAPSED];
      d.mask_a = wr_data_i[CTRL_A_MASK];
      d.mask_b = wr_data_i[CTRL_B_MASK];
    end
    // flags are sticky; a hardware set beats a clear in the same cycle
    d.el_a = d.el_a || set_a; // RQ21 RQ6
    d.el_b = d.el_b || set_b; // RQ21 RQ11

    // reads have no side effect on the flags
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL: begin
          d.rdata = {q.mask_b, 1'b0, q.el_b, q.run_b, q.mask_a, 1'b0, q.el_a, q.run_a};
        end
        ADDR_MODE: d.rdata = {q.csel_b, q.csel_a, 1'b0, q.mode};
        ADDR_A_LO: d.rdata = q.a_lo;
        ADDR_A_HI: d.rdata = q.a_hi;
        ADDR_B_LO: d.rdata = q.b_lo;
        ADDR_B_HI: d.rdata = q.b_hi;
        default: d.rdata = BYTE_ZERO;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0; // RQ19
    end else begin
      q <= d;
    end
  end

  assign rd_data_o = q.rdata;
  assign bit_strobe_o = q.strobe;
  assign irq_a_o = q.el_a && !q.mask_a; // RQ18
  assign irq_b_o = q.el_b && !q.mask_b; // RQ18

  // ****************************************
  // assertions
  // ****************************************
  a_no_strobe_mode0: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ16
    (q.mode == MODE_A16_RELOAD && !w_mode) |=> !bit_strobe_o)
    else $error("bit-rate strobe in mode 0");

  a_strobe_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ20
    bit_strobe_o |-> $past(b_active && tick_b && uf_b))
    else $error("strobe without timer B underrun");

  a_mask_blocks_irq: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ18
    (w_ctrl && wr_data_i[CTRL_A_MASK]) |=> !irq_a_o ##1 (!irq_a_o || !q.mask_a))
    else $error("masked timer A request seen");

  a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ21
    (w_ctrl && !wr_data_i[CTRL_A_ELAPSED] && set_a) |=> q.el_a)
    else $error("elapsed flag lost to software clear");

  a_mode0_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ6
    (q.mode == MODE_A16_RELOAD && q.run_a && tick_a && {q.a_hi, q.a_lo} == WORD_ZERO && !wr_i)
    |=> ({q.a_hi, q.a_lo} == $past({q.b_hi, q.b_lo}) && q.el_a && q.run_a))
    else $error("mode 0 reload wrong");

  a_oneshot_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ13
    (q.mode == MODE_A16_B16 && q.run_a && tick_a && {q.a_hi, q.a_lo} == WORD_ZERO && !wr_i)
    |=> (!q.run_a && q.el_a) ##1 ({q.a_hi, q.a_lo} == WORD_ONES || $past(wr_i)))
    else $error("one-shot timer A did not stop");

  a_split_free_run: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ10
    (q.mode == MODE_SPLIT_A && tick_b && q.b_lo == BYTE_ZERO && !wr_i)
    |=> (q.b_lo == $past(q.b_hi) && bit_strobe_o))
    else $error("split mode bit-rate timer not running");

  a_down_count: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ8
    (q.mode == MODE_A8_B8 && q.run_a && tick_a && q.a_lo != BYTE_ZERO && !wr_i)
    |=> (q.a_lo == $past(q.a_lo) - BYTE_ONE && !q.el_a == !$past(q.el_a)))
    else $error("8-bit timer A did not count down");

  a_cal_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ14
    (q.mode == MODE_CAL && q.cal == CAL_COUNT && lp_rise && !wr_i)
    |=> (!q.run_a && q.cal == CAL_IDLE) ##1 ({q.a_hi, q.a_lo} == $past({q.a_hi, q.a_lo}) || $past(wr_i)))
    else $error("calibration count not stopped at oscillator edge");

  // ****************************************
  // per-mode reload, one-shot and idle-timer checks
  // ****************************************
  a_mode4_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ11
    (q.mode == MODE_B16_RELOAD && q.run_b && tick_b && {q.b_hi, q.b_lo} == WORD_ZERO && !wr_i)
    |=> ({q.b_hi, q.b_lo} == $past({q.a_hi, q.a_lo}) && q.el_b && q.run_b && bit_strobe_o))
    else $error("mode 4 reload wrong");

  a_mode4_a_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ11
    (q.mode == MODE_B16_RELOAD && !wr_i)
    |=> ({q.a_hi, q.a_lo} == $past({q.a_hi, q.a_lo})))
    else $error("timer A moved in mode 4");

  a_b_oneshot_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ12
    (q.mode == MODE_A8_B16 && q.run_b && tick_b && {q.b_hi, q.b_lo} == WORD_ZERO && !wr_i)
    |=> (!q.run_b && q.el_b && {q.b_hi, q.b_lo} == WORD_ONES))
    else $error("one-shot timer B did not stop");

  a_b8_reload: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ7 RQ17
    ((q.mode == MODE_A16_B8 || q.mode == MODE_CAL) && q.run_b && tick_b && q.b_lo == BYTE_ZERO && !wr_i)
    |=> (q.b_lo == $past(q.b_hi) && q.el_b && q.run_b && bit_strobe_o))
    else $error("8-bit timer B reload wrong");

  a_split_high_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ9
    (q.mode == MODE_SPLIT_A && q.run_b && tick_a && q.a_hi == BYTE_ZERO && !wr_i)
    |=> (!q.run_b && q.el_b))
    else $error("split upper one-shot did not stop");

endmodule // dtm_timer

/* verification/dtm_far_side.sv */
// slow oscillator and external tick source facing the timer pair
module dtm_far_side #(
  parameter int LP_HALF = 50
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  output logic lp_osc_o,
  output logic ext_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q;

  // oscillator runs free, also outside any measurement
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 0;
      lp_osc_o <= 1'b0;
      ext_tick_o <= 1'b0;
    end else begin
      ext_tick_o <= ~ext_tick_o;
      if (cnt_q == LP_HALF - 1) begin
        cnt_q <= 0;
        lp_osc_o <= ~lp_osc_o;
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule // dtm_far_side

/* verification/dual_down_timer_eight_modes_test.sv */
// self-checking bench of the dual down-timer pair
module dual_down_timer_eight_modes_test import dtm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, wr, rd, ext_tick, lp_osc, strobe, irq_a, irq_b;
  logic [7:0] addr, wdat, rdat, v;
  logic [15:0] w;
  int err_count, checked, strobes, k, s0;

  dtm_timer #(.PRE_W(4)) uut (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wr_data_i(wdat),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .ext_tick_i(ext_tick), .lp_osc_i(lp_osc),
    .bit_strobe_o(strobe), .irq_a_o(irq_a), .irq_b_o(irq_b));
  dtm_far_side #(.LP_HALF(50)) far (.clk_i(clk), .rst_b_i(rst_b), .lp_osc_o(lp_osc),
    .ext_tick_o(ext_tick));

  always @(posedge clk) if (strobe === 1'b1) strobes <= strobes + 1;

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // one idle edge before each strobe, so no signal is driven twice per step
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rreg(a, d);
    chk(d, e);
  endtask

  // polls one control bit; n counts reads of two cycles each
  task automatic waitc(input int b, input logic val, output int n);
    logic [7:0] d;
    n = 0;
    do begin
      rreg(ADDR_CTRL, d);
      n++;
    end while (d[b] !== val && n < 3000);
    if (d[b] !== val) begin
      err_count++;
      results();
    end
  endtask

  task automatic results();
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdat = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    strobes = 0;
    err_count = 0;
    checked = 0;
    void'($urandom(32'hC270F3B2));
    repeat (16) @(posedge clk);
    #1 chk({irq_a, irq_b, strobe}, 16'h0000);
    @(posedge clk) rst_b <= 1'b1;
    // C7 and CE are unmapped and read zero
    for (int a = 8'hC7; a <= 8'hCE; a++) rchk(a[7:0], 8'h00);
    for (int m = 0; m < 8; m++) begin
      v = $urandom;
      wreg(ADDR_MODE, {v[7:4], 1'b1, m[2:0]});
      rchk(ADDR_MODE, {v[7:4], 1'b0, m[2:0]});
    end
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wreg(ADDR_B_LO + 8'(i), v);
      rchk(ADDR_B_LO + 8'(i), v);
    end
    // two 8-bit reloading timers, A masked
    wreg(ADDR_MODE, {CSEL_SYS, CSEL_SYS, 1'b0, MODE_A8_B8});
    v = 8'($urandom_range(20, 6));
    wreg(ADDR_A_LO, v);
    wreg(ADDR_A_HI, 8'h05);
    wreg(ADDR_B_LO, 8'h03);
    wreg(ADDR_B_HI, 8'h03);
    wreg(ADDR_CTRL, 8'h19);
    waitc(CTRL_A_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h3B);
    chk({irq_a, irq_b}, 16'h0001);
    s0 = strobes;
    repeat (40) @(posedge clk);
    chk(16'((strobes - s0) >= 9 && (strobes - s0) <= 11), 16'h0001);
    wreg(ADDR_CTRL, 8'h23);
    chk({irq_a, irq_b}, 16'h0003);
    rchk(ADDR_CTRL, 8'h23);
    // second write sure to clear: timer already stopped by the first
    wreg(ADDR_CTRL, 8'h00);
    wreg(ADDR_CTRL, 8'h00);
    chk({irq_a, irq_b}, 16'h0000);
    // two 16-bit one-shots, B on the external tick
    wreg(ADDR_MODE, {CSEL_EXT, CSEL_SYS, 1'b0, MODE_A16_B16});
    wreg(ADDR_A_LO, 8'h05);
    wreg(ADDR_A_HI, 8'h01);
    wreg(ADDR_B_LO, 8'h10);
    wreg(ADDR_B_HI, 8'h00);
    s0 = strobes;
    wreg(ADDR_CTRL, 8'h11);
    waitc(CTRL_B_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h21);
    rchk(ADDR_B_LO, 8'hFF);
    rchk(ADDR_B_HI, 8'hFF);
    chk(16'(strobes - s0), 16'h0001);
    waitc(CTRL_A_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h22);
    rchk(ADDR_A_LO, 8'hFF);
    rchk(ADDR_A_HI, 8'hFF);
    chk(16'(strobes - s0), 16'h0001);
    wreg(ADDR_CTRL, 8'h00);
    // 16-bit A reloading from B bytes
    wreg(ADDR_MODE, {4'h0, 1'b0, MODE_A16_RELOAD});
    wreg(ADDR_A_LO, 8'h03);
    wreg(ADDR_A_HI, 8'h00);
    wreg(ADDR_B_LO, 8'h07);
    wreg(ADDR_B_HI, 8'h00);
    wreg(ADDR_CTRL, 8'h01);
    waitc(CTRL_A_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h03);
    rchk(ADDR_CTRL, 8'h03);
    wreg(ADDR_CTRL, 8'h01);
    waitc(CTRL_A_ELAPSED, 1'b1, k);
    chk(16'(k <= 5), 16'h0001);
    wreg(ADDR_CTRL, 8'h00);
    wreg(ADDR_CTRL, 8'h00);
    // split A; B free-runs with no run bit
    wreg(ADDR_B_HI, 8'h04);
    wreg(ADDR_A_LO, 8'h05);
    wreg(ADDR_A_HI, 8'h30);
    wreg(ADDR_MODE, {4'h0, 1'b0, MODE_SPLIT_A});
    s0 = strobes;
    wreg(ADDR_CTRL, 8'h11);
    waitc(CTRL_A_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h12);
    waitc(CTRL_B_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h22);
    chk(16'((strobes - s0) >= 8), 16'h0001);
    wreg(ADDR_CTRL, 8'h00);
    // one oscillator period is 100 cycles
    wreg(ADDR_MODE, {4'h0, 1'b0, MODE_CAL});
    wreg(ADDR_A_LO, 8'h00);
    wreg(ADDR_A_HI, 8'h00);
    wreg(ADDR_CTRL, 8'h01);
    waitc(CTRL_A_RUN, 1'b0, k);
    rreg(ADDR_A_LO, w[7:0]);
    rreg(ADDR_A_HI, w[15:8]);
    chk(16'(w >= 16'h0063 && w <= 16'h0065), 16'h0001);
    rchk(ADDR_CTRL, 8'h00);
    // 16-bit B reloading from A bytes, A left alone
    wreg(ADDR_MODE, {4'h0, 1'b0, MODE_B16_RELOAD});
    wreg(ADDR_A_LO, 8'h06);
    wreg(ADDR_A_HI, 8'h00);
    wreg(ADDR_B_LO, 8'h03);
    wreg(ADDR_B_HI, 8'h00);
    s0 = strobes;
    wreg(ADDR_CTRL, 8'h10);
    waitc(CTRL_B_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h30);
    rchk(ADDR_A_LO, 8'h06);
    chk(16'((strobes - s0) >= 1), 16'h0001);
    wreg(ADDR_CTRL, 8'h10);
    waitc(CTRL_B_ELAPSED, 1'b1, k);
    chk(16'(k <= 5), 16'h0001);
    wreg(ADDR_CTRL, 8'h00);
    // A 16-bit one-shot beside B 8-bit reloading
    wreg(ADDR_MODE, {4'h0, 1'b0, MODE_A16_B8});
    wreg(ADDR_A_LO, 8'h02);
    wreg(ADDR_A_HI, 8'h00);
    wreg(ADDR_B_LO, 8'h01);
    wreg(ADDR_B_HI, 8'h01);
    wreg(ADDR_CTRL, 8'h11);
    waitc(CTRL_A_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h32);
    rchk(ADDR_A_HI, 8'hFF);
    wreg(ADDR_CTRL, 8'h00);
    // A 8-bit reloading beside B 16-bit one-shot
    wreg(ADDR_MODE, {4'h0, 1'b0, MODE_A8_B16});
    wreg(ADDR_A_LO, 8'h02);
    wreg(ADDR_A_HI, 8'h02);
    wreg(ADDR_B_LO, 8'h04);
    wreg(ADDR_B_HI, 8'h00);
    wreg(ADDR_CTRL, 8'h11);
    waitc(CTRL_B_ELAPSED, 1'b1, k);
    rchk(ADDR_CTRL, 8'h23);
    rchk(ADDR_B_HI, 8'hFF);
    wreg(ADDR_CTRL, 8'h00);
    results();
  end
endmodule // dual_down_timer_eight_modes_test
